// >>> logic/rbs_pkg.sv
package rbs_pkg;

    // ==========================================================
    // Timing
    localparam int RBS_CLK_HZ = 100_000_000;
    localparam int RBS_LOAD_TIME_MS = 100;
    localparam logic [23:0] RBS_LOAD_CYCLES = 24'(RBS_LOAD_TIME_MS * (RBS_CLK_HZ / 1000));
    localparam logic [9:0] RBS_HK_LAST = 10'h3ff;

    // ==========================================================
    // Slave register map (I2C subaddress)
    localparam logic [7:0] RBS_ADDR_LOAD_STATUS = 8'h02;
    localparam logic [31:0] RBS_LOAD_STATUS_RST = 32'h0000_0000;
    localparam int RBS_ST_DONE_BIT = 0;
    localparam int RBS_ST_FOUND_BIT = 1;
    localparam int RBS_ST_MEMERR_BIT = 2;
    localparam int RBS_ST_STRAP_BIT = 3;
    localparam int RBS_ST_TEST_BIT = 4;

    // Address bases are arbitrary; the select pin supplies bit 0
    localparam logic [6:0] RBS_SLAVE_ADDR_BASE = 7'h34;
    localparam logic [6:0] RBS_MASTER_ADDR_BASE = 7'h50;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        ST_HOUSEKEEP = 3'b000,
        ST_PROBE     = 3'b001,
        ST_STATUS    = 3'b010,
        ST_SLAVE_EN  = 3'b011,
        ST_GPIO_LOW  = 3'b100,
        ST_DONE      = 3'b101
    } rbs_state_t;

    typedef struct packed {
        logic done;
        logic found;
        logic mem_err;
    } rbs_probe_rsp_t;

    typedef struct packed {
        logic oe;
        logic out;
    } rbs_pin_drv_t;

endpackage

// >>> logic/rbs_top.sv
`timescale 1ns/1ps

module rbs_top
    import rbs_pkg::*;
#(
    parameter logic [23:0] LOAD_CYCLES = RBS_LOAD_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control pins
    input wire logic power_down_n,
    input wire logic i2c_addr_select,
    // General-purpose pin
    input wire logic gpio_in,
    output logic gpio_out,
    output logic gpio_oe,
    // Slave I2C pins, open drain
    input wire logic slave_i2c_clock_in,
    input wire logic slave_i2c_data_in,
    output logic slave_i2c_clock_out,
    output logic slave_i2c_clock_oe,
    output logic slave_i2c_data_out,
    output logic slave_i2c_data_oe,
    // Master I2C pins, open drain
    input wire logic master_i2c_clock_in,
    input wire logic master_i2c_data_in,
    output logic master_i2c_clock_out,
    output logic master_i2c_clock_oe,
    output logic master_i2c_data_out,
    output logic master_i2c_data_oe,
    // Slave I2C engine side
    input wire logic slv_eng_scl_low,
    input wire logic slv_eng_sda_low,
    input wire logic slv_rd_req,
    input wire logic [7:0] slv_rd_addr,
    output logic slv_rd_valid,
    output logic [31:0] slv_rd_data,
    output logic [6:0] slave_addr,
    output logic slave_en,
    // Master I2C engine side
    input wire logic mst_eng_scl_low,
    input wire logic mst_eng_sda_low,
    input wire rbs_probe_rsp_t probe_rsp,
    output logic probe_req,
    output logic [6:0] master_addr,
    output logic master_en,
    // Firmware control of the general-purpose pin
    input wire logic fw_gpio_wr,
    input wire rbs_pin_drv_t fw_gpio_drv,
    // Memory clearing
    output logic mem_clr_we,
    output logic [9:0] mem_clr_addr,
    // Core and clocks
    output logic core_idle,
    output logic clk_run,
    output logic init_done,
    // Serial audio
    input wire logic [3:0] serial_in_lane,
    input wire logic [3:0] dsp_out_lane,
    output logic [3:0] serial_out_lane
);

    // ==========================================================
    // State
    rbs_state_t state_q, state_d;
    logic [9:0] hk_cnt_q;
    logic hk_done_q;
    logic strap_q;
    logic [23:0] load_tmr_q;
    logic load_tmr_end;
    logic boot_ok_q;
    logic found_q;
    logic mem_err_q;
    logic slave_en_q;
    logic master_en_q;
    logic probe_req_q;
    rbs_pin_drv_t gpio_q;
    logic [31:0] load_status_q;
    logic rd_valid_q;
    logic [31:0] rd_data_q;
    logic [3:0] sout_q;
    logic clk_run_q;
    logic [6:0] slave_addr_q;
    logic [6:0] master_addr_q;

    assign load_tmr_end = (load_tmr_q >= LOAD_CYCLES);

    // ==========================================================
    // Sequencer
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_HOUSEKEEP: begin
                if (hk_done_q) begin
                    state_d = ST_PROBE;
                end
            end
            ST_PROBE: begin
                if (probe_rsp.done && probe_rsp.found && !probe_rsp.mem_err) begin
                    state_d = ST_STATUS;
                end else if (load_tmr_end) begin
                    state_d = ST_STATUS;
                end
            end
            ST_STATUS: state_d = ST_SLAVE_EN;
            ST_SLAVE_EN: state_d = boot_ok_q ? ST_DONE : ST_GPIO_LOW;
            ST_GPIO_LOW: state_d = ST_DONE;
            ST_DONE: state_d = ST_DONE;
            default: state_d = ST_HOUSEKEEP;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_HOUSEKEEP;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // Housekeeping: clear memory, sample strap
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hk_cnt_q <= 10'h000;
            hk_done_q <= 1'b0;
        end else if (state_q == ST_HOUSEKEEP && !hk_done_q) begin
            hk_cnt_q <= hk_cnt_q + 10'h001;
            hk_done_q <= (hk_cnt_q == RBS_HK_LAST);
        end
    end

    assign mem_clr_we = (state_q == ST_HOUSEKEEP) && !hk_done_q;
    assign mem_clr_addr = hk_cnt_q;

    // Strap caught while housekeeping runs, never at the reset edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap_q <= 1'b1;
        end else if (state_q == ST_HOUSEKEEP) begin
            strap_q <= gpio_in;
        end
    end

    // Addresses latched after release so the select pin is read cleanly
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slave_addr_q <= RBS_SLAVE_ADDR_BASE;
            master_addr_q <= RBS_MASTER_ADDR_BASE;
        end else if (state_q == ST_HOUSEKEEP) begin
            slave_addr_q <= {RBS_SLAVE_ADDR_BASE[6:1], i2c_addr_select};
            master_addr_q <= {RBS_MASTER_ADDR_BASE[6:1], i2c_addr_select};
        end
    end

    // ==========================================================
    // Load timer from reset release, saturating
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            load_tmr_q <= 24'h000000;
        end else if (!load_tmr_end) begin
            load_tmr_q <= load_tmr_q + 24'h000001;
        end
    end

    // ==========================================================
    // Probe and port enables
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            master_en_q <= 1'b0;
            probe_req_q <= 1'b0;
        end else begin
            master_en_q <= (state_d == ST_PROBE) || (master_en_q && state_q != ST_HOUSEKEEP);
            probe_req_q <= (state_q == ST_HOUSEKEEP) && (state_d == ST_PROBE);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            found_q <= 1'b0;
            mem_err_q <= 1'b0;
            boot_ok_q <= 1'b0;
        end else if (state_q == ST_PROBE && probe_rsp.done) begin
            found_q <= probe_rsp.found;
            mem_err_q <= probe_rsp.mem_err;
            boot_ok_q <= probe_rsp.found && !probe_rsp.mem_err;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slave_en_q <= 1'b0;
        end else if (state_q == ST_SLAVE_EN) begin
            slave_en_q <= 1'b1;
        end
    end

    // ==========================================================
    // Load status register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            load_status_q <= RBS_LOAD_STATUS_RST;
        end else if (state_q == ST_STATUS) begin
            load_status_q[RBS_ST_DONE_BIT] <= 1'b1;
            load_status_q[RBS_ST_FOUND_BIT] <= found_q;
            load_status_q[RBS_ST_MEMERR_BIT] <= mem_err_q;
            load_status_q[RBS_ST_STRAP_BIT] <= strap_q;
            load_status_q[RBS_ST_TEST_BIT] <= !boot_ok_q && !strap_q;
        end
    end

    // Reads answered only once the slave port is live; unmapped reads zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_valid_q <= 1'b0;
            rd_data_q <= 32'h0000_0000;
        end else begin
            rd_valid_q <= slv_rd_req && slave_en_q;
            if (slv_rd_req && slave_en_q) begin
                rd_data_q <= (slv_rd_addr == RBS_ADDR_LOAD_STATUS) ? load_status_q : 32'h0000_0000;
            end
        end
    end

    // ==========================================================
    // General-purpose pin
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gpio_q <= '{oe: 1'b0, out: 1'b0};
        end else if (state_q == ST_GPIO_LOW) begin
            gpio_q <= '{oe: 1'b1, out: 1'b0};
        end else if (state_q == ST_DONE && fw_gpio_wr) begin
            gpio_q <= fw_gpio_drv;
        end
    end

    // ==========================================================
    // Serial outputs and clock gating
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sout_q <= 4'h0;
        end else if (state_q != ST_DONE) begin
            sout_q <= 4'h0;
        end else if (boot_ok_q) begin
            sout_q <= dsp_out_lane;
        end else if (!strap_q) begin
            sout_q <= serial_in_lane;
        end else begin
            sout_q <= 4'h0;
        end
    end

    // State is never reset by power-down, only the clock enable drops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_run_q <= 1'b0;
        end else begin
            clk_run_q <= power_down_n;
        end
    end

    // ==========================================================
    // Outputs
    assign init_done = (state_q == ST_DONE);
    assign core_idle = !(init_done && boot_ok_q);
    assign clk_run = clk_run_q;
    assign slave_en = slave_en_q;
    assign master_en = master_en_q;
    assign probe_req = probe_req_q;
    assign slave_addr = slave_addr_q;
    assign master_addr = master_addr_q;
    assign slv_rd_valid = rd_valid_q;
    assign slv_rd_data = rd_data_q;
    assign gpio_out = gpio_q.out;
    assign gpio_oe = gpio_q.oe;
    assign serial_out_lane = sout_q;
    // Open-drain: pins only ever pull low, released until the port is live
    assign slave_i2c_clock_out = 1'b0;
    assign slave_i2c_data_out = 1'b0;
    assign master_i2c_clock_out = 1'b0;
    assign master_i2c_data_out = 1'b0;
    assign slave_i2c_clock_oe = slave_en_q && init_done && slv_eng_scl_low;
    assign slave_i2c_data_oe = slave_en_q && init_done && slv_eng_sda_low;
    assign master_i2c_clock_oe = master_en_q && mst_eng_scl_low;
    assign master_i2c_data_oe = master_en_q && mst_eng_sda_low;

    // ==========================================================
    // Checks
    sequence s_slave_then_gpio;
        (state_q == ST_SLAVE_EN && !slave_en_q) ##1 (slave_en_q && !gpio_q.oe) ##1 (gpio_q.oe && !gpio_q.out);
    endsequence

    a_fallback_order: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == ST_STATUS && !boot_ok_q) |=> s_slave_then_gpio)
        else $error("fallback order wrong");

    a_test_pin_low: assert property (@(posedge clk) disable iff (!rst_n)
        ($rose(init_done) && !boot_ok_q && !strap_q) |-> gpio_q.oe && !gpio_q.out)
        else $error("test mode pin not driven");

    a_i2c_hiz_init: assert property (@(posedge clk) disable iff (!rst_n)
        !init_done |-> !slave_i2c_clock_oe && !slave_i2c_data_oe)
        else $error("slave lines driven before init done");

    a_master_slave_split: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == ST_PROBE) |-> master_en_q && !slave_en_q && hk_done_q)
        else $error("port enables wrong during probe");

    a_probe_master_on: assert property (@(posedge clk) disable iff (!rst_n)
        probe_req_q |-> master_en_q ##1 !probe_req_q)
        else $error("probe without master port");

    a_housekeep_first: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(master_en_q) |-> $past(hk_cnt_q) == 10'h000 && $past(hk_done_q))
        else $error("master enabled before housekeeping");

    a_gpio_input_init: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q inside {ST_HOUSEKEEP, ST_PROBE, ST_STATUS}) |-> !gpio_q.oe)
        else $error("pin driven during init");

    a_status_read: assert property (@(posedge clk) disable iff (!rst_n)
        (slv_rd_req && slave_en_q && slv_rd_addr == RBS_ADDR_LOAD_STATUS)
        |=> slv_rd_valid && slv_rd_data == $past(load_status_q))
        else $error("status read mismatch");

    a_passthru: assert property (@(posedge clk) disable iff (!rst_n)
        (init_done && !boot_ok_q && !strap_q) |=> serial_out_lane == $past(serial_in_lane))
        else $error("test pass-through broken");

    a_default_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        (!boot_ok_q && strap_q) |-> ##1 serial_out_lane == 4'h0)
        else $error("outputs active in default mode");

    a_load_time: assert property (@(posedge clk) disable iff (!rst_n)
        (state_q == ST_STATUS && !boot_ok_q) |-> load_tmr_end)
        else $error("fallback finished before load time");

    a_no_read_early: assert property (@(posedge clk) disable iff (!rst_n)
        !slave_en_q |=> !slv_rd_valid)
        else $error("read answered while slave disabled");

endmodule

// >>> sim/rbs_eeprom_model.sv
`timescale 1ns/1ps

// ==========================================================
// Boot memory behind the master port, answering one probe
module rbs_eeprom_model
    import rbs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Probe link
    input wire logic probe_req,
    input wire logic present,
    input wire logic bad_read,
    output rbs_probe_rsp_t rsp
);
    logic [3:0] wait_q;

    // Answers some cycles late, as a real part would
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 4'h0;
            rsp <= '0;
        end else begin
            rsp <= '0;
            if (probe_req) begin
                wait_q <= 4'h6;
            end else if (wait_q != 4'h0) begin
                wait_q <= wait_q - 4'h1;
            end
            if (wait_q == 4'h1) begin
                rsp <= '{done: 1'b1, found: present, mem_err: bad_read};
            end
        end
    end
endmodule

// >>> sim/rbs_top_bench.sv
`timescale 1ns/1ps

module rbs_top_bench
    import rbs_pkg::*;
;
    // ==========================================================
    // Stimulus and wires
    localparam logic [23:0] LOADC = 24'h0007d0;
    typedef struct {logic strap; logic found; logic err; logic sel; logic [31:0] st; int mode;} rbs_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic pwr_n = 1'b1, sel = 1'b0, strap = 1'b1, eng_low = 1'b1;
    logic rd_req = 1'b0, fw_wr = 1'b0, present = 1'b0, bad_rd = 1'b0;
    logic [7:0] rd_addr = 8'h00;
    logic [3:0] sin = 4'h5, dsp = 4'ha, sout;
    rbs_pin_drv_t fw_drv = '0;
    rbs_probe_rsp_t rsp;
    logic gpio_out, gpio_oe, s_c_oe, s_d_oe, m_c_oe, m_d_oe, rd_valid, slave_en, master_en;
    logic probe_req, mem_we, core_idle, clk_run, init_done;
    logic [31:0] rd_data;
    logic [6:0] slave_addr, master_addr;
    logic [9:0] mem_addr;
    int bad_count = 0, cmp_count = 0;
    // Strap level on the pin when released, pull-ups on the open-drain lines
    wire gpio_in = gpio_oe ? gpio_out : strap;
    rbs_row_t rows[4] = '{
        '{1'b1, 1'b0, 1'b0, 1'b0, 32'h00000009, 0},
        '{1'b1, 1'b1, 1'b1, 1'b1, 32'h0000000f, 0},
        '{1'b0, 1'b1, 1'b0, 1'b1, 32'h00000003, 2},
        '{1'b0, 1'b0, 1'b0, 1'b0, 32'h00000011, 1}};

    always #5 clk = ~clk;

    rbs_top #(.LOAD_CYCLES(LOADC)) dut (
        .clk(clk), .rst_n(rst_n), .power_down_n(pwr_n), .i2c_addr_select(sel),
        .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .slave_i2c_clock_in(!s_c_oe), .slave_i2c_data_in(!s_d_oe),
        .slave_i2c_clock_out(), .slave_i2c_clock_oe(s_c_oe), .slave_i2c_data_out(), .slave_i2c_data_oe(s_d_oe),
        .master_i2c_clock_in(!m_c_oe), .master_i2c_data_in(!m_d_oe),
        .master_i2c_clock_out(), .master_i2c_clock_oe(m_c_oe), .master_i2c_data_out(), .master_i2c_data_oe(m_d_oe),
        .slv_eng_scl_low(eng_low), .slv_eng_sda_low(eng_low), .slv_rd_req(rd_req), .slv_rd_addr(rd_addr),
        .slv_rd_valid(rd_valid), .slv_rd_data(rd_data), .slave_addr(slave_addr), .slave_en(slave_en),
        .mst_eng_scl_low(eng_low), .mst_eng_sda_low(eng_low), .probe_rsp(rsp), .probe_req(probe_req),
        .master_addr(master_addr), .master_en(master_en), .fw_gpio_wr(fw_wr), .fw_gpio_drv(fw_drv),
        .mem_clr_we(mem_we), .mem_clr_addr(mem_addr), .core_idle(core_idle), .clk_run(clk_run),
        .init_done(init_done), .serial_in_lane(sin), .dsp_out_lane(dsp), .serial_out_lane(sout));

    rbs_eeprom_model eeprom (.clk(clk), .rst_n(rst_n), .probe_req(probe_req), .present(present),
        .bad_read(bad_rd), .rsp(rsp));

    // ==========================================================
    // Tasks
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic summarize();
        $display("counts: %0d compares, %0d mismatches", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        step();
        rd_req = 1'b1;
        rd_addr = a;
        step();
        rd_req = 1'b0;
        check({what, " valid"}, 1, rd_valid);
        check(what, exp, rd_data);
    endtask

    // Reset, boot, then look at every result of the sequence
    task automatic boot(input rbs_row_t r);
        int n;
        logic se_prev;
        step();
        rst_n = 1'b0;
        present = r.found;
        bad_rd = r.err;
        strap = r.strap;
        sel = r.sel;
        rd_req = 1'b1;
        repeat (5) step();
        check("reset pin oe", 0, gpio_oe);
        check("reset slave", 0, slave_en);
        check("reset master", 0, master_en);
        check("reset idle", 1, core_idle);
        check("reset sda oe", 0, m_d_oe);
        check("reset read", 0, rd_valid);
        check("reset sout", 0, sout);
        rst_n = 1'b1;
        n = 0;
        se_prev = 1'b0;
        // Requests stay up: none may be served before the slave port opens
        while (init_done !== 1'b1) begin
            step();
            n++;
            if (se_prev !== 1'b1) check("early read", 0, rd_valid);
            if (gpio_oe === 1'b1 && se_prev !== 1'b1) check("pin before slave", 0, 1);
            if (init_done !== 1'b1) check("slave sda oe", 0, s_d_oe);
            if (n == 1) check("hk clear", 1, mem_we);
            if (n == 1023) check("hk last addr", 10'h3ff, mem_addr);
            if (n == 1024) check("hk end", 0, mem_we);
            if (probe_req === 1'b1) begin
                check("probe cycle", 1025, n);
                check("probe master", 1, master_en);
                check("probe scl oe", 1, m_c_oe);
                check("probe slave", 0, slave_en);
            end
            se_prev = slave_en;
            if (n > LOADC + 100) begin
                check("init timeout", 1, 0);
                summarize();
            end
        end
        rd_req = 1'b0;
        if (r.mode != 2) check("load time", 1, n >= LOADC - 2 && n <= LOADC + 8);
        else check("boot time", 1, n < 1100);
        check("pin oe", r.mode != 2, gpio_oe);
        check("pin level", 0, gpio_out);
        check("idle", r.mode != 2, core_idle);
        rd(RBS_ADDR_LOAD_STATUS, r.st, "status");
        rd(8'h7f, 32'h00000000, "unmapped");
        check("slave addr", {RBS_SLAVE_ADDR_BASE[6:1], r.sel}, slave_addr);
        check("master addr", {RBS_MASTER_ADDR_BASE[6:1], r.sel}, master_addr);
        check("slave sda oe on", 1, s_d_oe);
        check("slave scl oe on", 1, s_c_oe);
        for (int k = 0; k < 2; k++) begin
            sin = k ? 4'hc : 4'h5;
            dsp = k ? 4'h3 : 4'ha;
            step();
            step();
            check("sout", r.mode == 1 ? sin : (r.mode == 2 ? dsp : 4'h0), sout);
        end
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        foreach (rows[i]) begin
            boot(rows[i]);
            $display("test %0d done", i);
        end
        // Reset in mid-clearing must restart the whole sequence
        step();
        rst_n = 1'b0;
        step();
        rst_n = 1'b1;
        repeat (300) step();
        check("mid clear", 1, mem_we);
        boot(rows[0]);
        $display("test restart done");
        fw_drv = '{oe: 1'b1, out: 1'b1};
        fw_wr = 1'b1;
        step();
        fw_wr = 1'b0;
        check("fw pin", 1, gpio_out);
        pwr_n = 1'b0;
        step();
        check("clk stop", 0, clk_run);
        check("state kept", 1, init_done);
        pwr_n = 1'b1;
        step();
        check("clk run", 1, clk_run);
        $display("test pin and power done");
        // Engine letting go must release both open-drain ports
        eng_low = 1'b0;
        #1;
        check("slave line free", 0, s_d_oe);
        check("master line free", 0, m_c_oe);
        #3;
        rst_n = 1'b0;
        #1;
        check("async pin", 0, gpio_oe);
        check("async slave", 0, slave_en);
        check("async done", 0, init_done);
        $display("test async reset done");
        summarize();
    end
endmodule
